// *** adc_seq_pkg.sv ***
// shared constants and types for the converter sequencer and its controller
package adc_seq_pkg;

  // ***********************************************************************
  // clock period in ns, conversion timing in core_clk periods, counter width
  // ***********************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int CYCLE_CLKS = 40002;
  localparam int INT_CLKS = 10000;
  localparam int DEINT_MAX_CLKS = 20001;
  localparam int CNT_W = 16;

  // ***********************************************************************
  // readout timing and result limits
  // ***********************************************************************
  localparam int NUM_DIGITS = 5;
  localparam int UPDATE_CLKS = 800;
  localparam int DIGIT_CLKS = UPDATE_CLKS / (NUM_DIGITS - 1);
  localparam int STROBE_POS = DIGIT_CLKS / 2;
  localparam int DIG_CNT_W = 8;
  localparam int UNDER_LIMIT = 1800;
  localparam int OVER_LIMIT = 19999;

  // ***********************************************************************
  // serial word framing
  // ***********************************************************************
  localparam int BAUD_DIV = 16;
  localparam int FRAME_BITS = 11;
  localparam logic [3:0] TAG_DIG5 = 4'h0;
  localparam logic [3:0] TAG_DIG4 = 4'h8;
  localparam logic [3:0] TAG_DIG3 = 4'h4;
  localparam logic [3:0] TAG_DIG2 = 4'hC;
  localparam logic [3:0] TAG_DIG1 = 4'h2;

  // ***********************************************************************
  // controller register map, byte offsets
  // ***********************************************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] DATA_OFF = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
  localparam logic [7:0] IRQ_CLR_OFF = 8'h10;
  localparam logic [7:0] IRQ_EN_OFF = 8'h14;
  localparam int CTRL_FREE_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_RANK2_BIT = 1;
  localparam logic CTRL_FREE_RST = 1'b0;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;

  typedef enum logic [1:0] {
    PH_HOLD,
    PH_SIG_INT,
    PH_DEINT,
    PH_ZERO
  } phase_t;

endpackage

// *** adc_link_if.sv ***
// link between the converter sequencer and its outside logic
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic run_hold;
  logic busy;
  logic strobe_n;
  logic [4:0] digit_sel;
  logic [3:0] bcd;
  logic polarity;
  logic over_range;
  logic under_range;

  modport dev (
    input run_hold,
    output busy, strobe_n, digit_sel, bcd, polarity, over_range, under_range
  );
  modport ctl (
    output run_hold,
    input busy, strobe_n, digit_sel, bcd, polarity, over_range, under_range
  );
endinterface
`default_nettype wire

// *** adc_seq_dev.sv ***
// dual-slope conversion sequencer with multiplexed bcd readout
//
// Summary of operation
// - full cycle is exactly 40,002 clocks
// - signal integration lasts fixed 10,000 clocks
// - de-integration length follows the input level
// - strobe sits mid-digit, data stable around it
// - 800-clock update, top digit new first
// - digit selects are one-hot, five positions
// - over-range may blank all digit selects
// - run/hold high starts a new conversion
// - busy falls when a conversion ends
// - outside second rank loads on top select
// - transmitter sends one word per strobe
// - upper nibble tags the digit position
// - polarity selects even parity of word
// - request mode overlays flags on top word
// - each word ends before next strobe
// - five strobes right after busy falls
// - range flags set when busy ends
// - under clears at integrate, over at de-integrate
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_dev #(
  parameter int CYCLE_CLKS = adc_seq_pkg::CYCLE_CLKS,
  parameter int INT_CLKS = adc_seq_pkg::INT_CLKS,
  parameter int DEINT_MAX_CLKS = adc_seq_pkg::DEINT_MAX_CLKS
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // analog front end pins
  input wire logic comp_pin,
  input wire logic sign_pin,
  output logic [1:0] phase,
  // link to outside logic
  adc_link_if.dev link
);

  // ***********************************************************************
  // pin synchronisers
  // ***********************************************************************
  logic comp_meta_q, comp_q, sign_meta_q, sign_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      comp_meta_q <= 1'b0;
      comp_q <= 1'b0;
      sign_meta_q <= 1'b0;
      sign_q <= 1'b0;
    end else if (clk_en) begin
      comp_meta_q <= comp_pin;
      comp_q <= comp_meta_q;
      sign_meta_q <= sign_pin;
      sign_q <= sign_meta_q;
    end
  end

  // ***********************************************************************
  // conversion phases
  // ***********************************************************************
  adc_seq_pkg::phase_t phase_q;
  logic [adc_seq_pkg::CNT_W-1:0] cyc_q, deint_q;
  logic cyc_last, int_last, deint_done, end_conv;

  assign cyc_last = (cyc_q == adc_seq_pkg::CNT_W'(CYCLE_CLKS - 1));
  assign int_last = (cyc_q == adc_seq_pkg::CNT_W'(INT_CLKS - 1));
  // crossing or time-out ends de-integration
  assign deint_done = !comp_q ||
    (deint_q == adc_seq_pkg::CNT_W'(DEINT_MAX_CLKS - 1));
  assign end_conv = (phase_q == adc_seq_pkg::PH_DEINT) && deint_done;
  assign phase = phase_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_q <= adc_seq_pkg::PH_HOLD;
    end else if (clk_en) begin
      case (phase_q)
        adc_seq_pkg::PH_HOLD: begin
          if (link.run_hold) begin
            phase_q <= adc_seq_pkg::PH_SIG_INT;
          end
        end
        adc_seq_pkg::PH_SIG_INT: begin
          if (int_last) begin
            phase_q <= adc_seq_pkg::PH_DEINT;
          end
        end
        adc_seq_pkg::PH_DEINT: begin
          if (deint_done) begin
            phase_q <= adc_seq_pkg::PH_ZERO;
          end
        end
        adc_seq_pkg::PH_ZERO: begin
          if (cyc_last) begin
            phase_q <= link.run_hold ? adc_seq_pkg::PH_SIG_INT
                                     : adc_seq_pkg::PH_HOLD;
          end
        end
        default: begin
          phase_q <= adc_seq_pkg::PH_HOLD;
        end
      endcase
    end
  end

  // cycle count from integrate start, wraps at the cycle length
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cyc_q <= '0;
    end else if (clk_en) begin
      if (phase_q == adc_seq_pkg::PH_HOLD || cyc_last) begin
        cyc_q <= '0;
      end else begin
        cyc_q <= cyc_q + 1'b1;
      end
    end
  end

  // ***********************************************************************
  // de-integration count, binary and bcd
  // ***********************************************************************
  logic [3:0] cnt_bcd_q [adc_seq_pkg::NUM_DIGITS];
  logic [3:0] res_q [adc_seq_pkg::NUM_DIGITS];
  logic [adc_seq_pkg::NUM_DIGITS-1:0] carry;
  always_comb begin
    carry[0] = 1'b1;
    for (int i = 1; i < adc_seq_pkg::NUM_DIGITS; i++)
      carry[i] = carry[i-1] && (cnt_bcd_q[i-1] == 4'h9);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      deint_q <= '0;
    end else if (clk_en) begin
      if (phase_q == adc_seq_pkg::PH_SIG_INT) begin
        deint_q <= '0;
      end else if (phase_q == adc_seq_pkg::PH_DEINT && !deint_done) begin
        deint_q <= deint_q + 1'b1;
      end
    end
  end

  // decimal counter, index 0 is least significant
  always_ff @(posedge core_clk) begin
    if (rst || (clk_en && phase_q == adc_seq_pkg::PH_SIG_INT)) begin
      for (int i = 0; i < adc_seq_pkg::NUM_DIGITS; i++) begin
        cnt_bcd_q[i] <= 4'h0;
      end
    end else if (clk_en && phase_q == adc_seq_pkg::PH_DEINT &&
                 !deint_done) begin
      for (int i = 0; i < adc_seq_pkg::NUM_DIGITS; i++) begin
        if (carry[i]) begin
          cnt_bcd_q[i] <= (cnt_bcd_q[i] == 4'h9 &&
            i < adc_seq_pkg::NUM_DIGITS - 1) ? 4'h0 : cnt_bcd_q[i] + 4'h1;
        end
      end
    end
  end

  // result taken when busy falls
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < adc_seq_pkg::NUM_DIGITS; i++) begin
        res_q[i] <= 4'h0;
      end
    end else if (clk_en && end_conv) begin
      for (int i = 0; i < adc_seq_pkg::NUM_DIGITS; i++) begin
        res_q[i] <= cnt_bcd_q[i];
      end
    end
  end

  // ***********************************************************************
  // busy, polarity and range flags
  // ***********************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link.busy <= 1'b0;
    end else if (clk_en) begin
      link.busy <= (phase_q == adc_seq_pkg::PH_SIG_INT) ||
        (phase_q == adc_seq_pkg::PH_DEINT && !deint_done);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      link.polarity <= 1'b0;
      link.under_range <= 1'b0;
      link.over_range <= 1'b0;
    end else if (clk_en) begin
      if (phase_q == adc_seq_pkg::PH_SIG_INT && int_last) begin
        link.polarity <= sign_q;
        link.over_range <= 1'b0;
      end
      if (phase_q != adc_seq_pkg::PH_SIG_INT &&
          link.run_hold && (phase_q == adc_seq_pkg::PH_HOLD || cyc_last)) begin
        link.under_range <= 1'b0;
      end
      if (end_conv) begin
        link.under_range <=
          (deint_q <= adc_seq_pkg::CNT_W'(adc_seq_pkg::UNDER_LIMIT));
        link.over_range <=
          (deint_q > adc_seq_pkg::CNT_W'(adc_seq_pkg::OVER_LIMIT));
      end
    end
  end

  // ***********************************************************************
  // digit scan and strobes
  // ***********************************************************************
  logic [2:0] idx_q, strobes_q;
  logic [adc_seq_pkg::DIG_CNT_W-1:0] dcnt_q;
  logic dig_last, strobe_now;

  assign dig_last =
    (dcnt_q == adc_seq_pkg::DIG_CNT_W'(adc_seq_pkg::DIGIT_CLKS - 1));
  assign strobe_now = (strobes_q != 3'h0) &&
    (dcnt_q == adc_seq_pkg::DIG_CNT_W'(adc_seq_pkg::STROBE_POS));

  // index 0 shows the top digit; restart at busy fall
  always_ff @(posedge core_clk) begin
    if (rst) begin
      idx_q <= 3'h0;
      dcnt_q <= '0;
    end else if (clk_en) begin
      if (end_conv) begin
        idx_q <= 3'h0;
        dcnt_q <= '0;
      end else if (dig_last) begin
        dcnt_q <= '0;
        idx_q <= (idx_q == 3'(adc_seq_pkg::NUM_DIGITS - 1)) ? 3'h0
                                                         : idx_q + 3'h1;
      end else begin
        dcnt_q <= dcnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      strobes_q <= 3'h0;
    end else if (clk_en) begin
      if (end_conv) begin
        strobes_q <= 3'(adc_seq_pkg::NUM_DIGITS);
      end else if (strobe_now) begin
        strobes_q <= strobes_q - 3'h1;
      end
    end
  end

  // outputs registered together so strobe, select and data stay aligned
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link.strobe_n <= 1'b1;
      link.digit_sel <= 5'h00;
      link.bcd <= 4'h0;
    end else if (clk_en) begin
      link.strobe_n <= !strobe_now;
      link.bcd <= res_q[3'(adc_seq_pkg::NUM_DIGITS - 1) - idx_q];
      if ((end_conv ? (cnt_bcd_q[adc_seq_pkg::NUM_DIGITS-1] > 4'h1)
                    : link.over_range)) begin
        link.digit_sel <= 5'h00;
      end else begin
        link.digit_sel <= 5'h10 >> idx_q;
      end
    end
  end

endmodule
`default_nettype wire

// *** adc_seq_ctl.sv ***
// outside logic: run request, digit latches and serial word sender
`timescale 1ns/1ps
`default_nettype none
module adc_seq_ctl (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt and serial output
  output logic irq,
  output logic tx_out,
  // link to the sequencer
  adc_link_if.ctl link
);

  // ***********************************************************************
  // apb access and registers
  // ***********************************************************************
  logic wr_acc, mapped, busy_q, top_q, busy_fall, top_rise, strobe;
  logic free_q, req_q;
  logic [1:0] irq_stat_q, irq_en_q;
  logic [3:0] rank1_q [adc_seq_pkg::NUM_DIGITS];
  logic [19:0] rank2_q;

  assign mapped = (paddr <= adc_seq_pkg::IRQ_EN_OFF) && (paddr[1:0] == 2'h0);
  assign wr_acc = psel && penable && pwrite && clk_en;
  assign pready = penable;
  assign pslverr = penable && !mapped;
  assign busy_fall = busy_q && !link.busy;
  assign top_rise = !top_q && link.digit_sel[4];
  assign strobe = !link.strobe_n;
  assign link.run_hold = free_q || req_q;
  assign irq = |(irq_stat_q & irq_en_q);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      case (paddr)
        adc_seq_pkg::CTRL_OFF: prdata <= {31'h0, free_q};
        adc_seq_pkg::STATUS_OFF: prdata <= {27'h0, link.under_range,
          link.over_range, link.polarity, link.busy, req_q};
        adc_seq_pkg::DATA_OFF: prdata <= {12'h000, rank2_q};
        adc_seq_pkg::IRQ_STAT_OFF: prdata <= {30'h0, irq_stat_q};
        adc_seq_pkg::IRQ_EN_OFF: prdata <= {30'h0, irq_en_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      free_q <= adc_seq_pkg::CTRL_FREE_RST;
      irq_en_q <= adc_seq_pkg::IRQ_EN_RST;
    end else if (wr_acc && paddr == adc_seq_pkg::CTRL_OFF) begin
      free_q <= pwdata[adc_seq_pkg::CTRL_FREE_BIT];
    end else if (wr_acc && paddr == adc_seq_pkg::IRQ_EN_OFF) begin
      irq_en_q <= pwdata[1:0];
    end
  end

  // request set by software, cleared by busy falling; set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_acc && paddr == adc_seq_pkg::CTRL_OFF &&
          pwdata[adc_seq_pkg::CTRL_GO_BIT]) begin
        req_q <= 1'b1;
      end else if (busy_fall) begin
        req_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_stat_q <= 2'h0;
    end else if (clk_en) begin
      irq_stat_q <= (irq_stat_q & ~((wr_acc &&
        paddr == adc_seq_pkg::IRQ_CLR_OFF) ? pwdata[1:0] : 2'h0)) |
        {top_rise, busy_fall};
    end
  end

  // ***********************************************************************
  // digit latches
  // ***********************************************************************
  logic [2:0] dig_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      top_q <= 1'b0;
      dig_q <= 3'h0;
    end else if (clk_en) begin
      busy_q <= link.busy;
      top_q <= link.digit_sel[4];
      if (busy_fall) begin
        dig_q <= 3'h0;
      end else if (strobe) begin
        dig_q <= dig_q + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < adc_seq_pkg::NUM_DIGITS; i++) begin
        rank1_q[i] <= 4'h0;
      end
      rank2_q <= 20'h00000;
    end else if (clk_en) begin
      if (strobe && dig_q < 3'(adc_seq_pkg::NUM_DIGITS)) begin
        rank1_q[dig_q] <= link.bcd;
      end
      if (top_rise) begin
        rank2_q <= {rank1_q[0], rank1_q[1], rank1_q[2], rank1_q[3],
                    rank1_q[4]};
      end
    end
  end

  // ***********************************************************************
  // serial word sender: start, 8 data lsb first, parity, stop
  // ***********************************************************************
  logic [3:0] tag;
  logic [7:0] word;
  logic [10:0] shift_q;
  logic [3:0] bits_q, baud_q;

  always_comb begin
    case (dig_q)
      3'h0: tag = adc_seq_pkg::TAG_DIG5;
      3'h1: tag = adc_seq_pkg::TAG_DIG4;
      3'h2: tag = adc_seq_pkg::TAG_DIG3;
      3'h3: tag = adc_seq_pkg::TAG_DIG2;
      default: tag = adc_seq_pkg::TAG_DIG1;
    endcase
    word = {tag, link.bcd};
    if (!free_q && dig_q == 3'h0) begin
      word[3:1] = {link.polarity, link.over_range, link.under_range};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_q <= 11'h7FF;
      bits_q <= 4'h0;
      baud_q <= 4'h0;
    end else if (clk_en) begin
      if (strobe) begin
        // polarity high means even parity
        shift_q <= {1'b1, link.polarity ? ^word : ~^word, word, 1'b0};
        bits_q <= 4'(adc_seq_pkg::FRAME_BITS);
        baud_q <= 4'(adc_seq_pkg::BAUD_DIV - 1);
      end else if (bits_q != 4'h0) begin
        if (baud_q == 4'h0) begin
          // frame of 176 clocks ends before the next strobe
          baud_q <= 4'(adc_seq_pkg::BAUD_DIV - 1);
          shift_q <= {1'b1, shift_q[10:1]};
          bits_q <= bits_q - 4'h1;
        end else begin
          baud_q <= baud_q - 4'h1;
        end
      end
    end
  end

  assign tx_out = (bits_q != 4'h0) ? shift_q[0] : 1'b1;

endmodule
`default_nettype wire

// *** adc_seq_assertions.sv ***
// concurrent checks on the converter link
`timescale 1ns/1ps
`default_nettype none
module adc_seq_assertions #(
  parameter int CYCLE_CLKS = adc_seq_pkg::CYCLE_CLKS,
  parameter int INT_CLKS = adc_seq_pkg::INT_CLKS,
  parameter int DEINT_MAX_CLKS = adc_seq_pkg::DEINT_MAX_CLKS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link signals
  input wire logic run_hold,
  input wire logic busy,
  input wire logic strobe_n,
  input wire logic [4:0] digit_sel,
  input wire logic [3:0] bcd,
  input wire logic polarity,
  input wire logic over_range,
  input wire logic under_range
);
  // ********************
  // helper counters
  // ********************
  logic [15:0] busy_len_q, period_q, wait_q;
  logic [2:0] strobes_q;
  logic rose_seen_q, fell_seen_q;

  always_ff @(posedge core_clk) begin
    if (rst || !busy) busy_len_q <= 16'h0000;
    else busy_len_q <= busy_len_q + 16'h0001;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      period_q <= 16'h0000;
      rose_seen_q <= 1'b0;
    end else if ($rose(busy)) begin
      period_q <= 16'h0001;
      rose_seen_q <= 1'b1;
    end else if (period_q != 16'hFFFF) period_q <= period_q + 16'h0001;
  end

  always_ff @(posedge core_clk) begin
    if (rst || busy || !run_hold) wait_q <= 16'h0000;
    else if (wait_q != 16'hFFFF) wait_q <= wait_q + 16'h0001;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      strobes_q <= 3'h0;
      fell_seen_q <= 1'b0;
    end else if ($fell(busy)) begin
      strobes_q <= 3'h0;
      fell_seen_q <= 1'b1;
    end else if (!strobe_n && strobes_q != 3'h7) strobes_q <= strobes_q + 3'h1;
  end

  // ********************
  // properties
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_steady;
    ($stable(digit_sel) && $stable(bcd)) [*8];
  endsequence
  sequence s_first_strobe;
    ##[90:115] $fell(strobe_n);
  endsequence

  property p_period;
    $rose(busy) && rose_seen_q |-> period_q >= CYCLE_CLKS;
  endproperty
  property p_busy_len;
    $fell(busy) |-> busy_len_q > INT_CLKS &&
      busy_len_q <= INT_CLKS + DEINT_MAX_CLKS + 2;
  endproperty
  property p_strobe_mid;
    $fell(strobe_n) |-> digit_sel == $past(digit_sel, 8) ##1 s_steady;
  endproperty
  property p_first;
    $fell(busy) |-> s_first_strobe;
  endproperty
  property p_strobe_cnt;
    $fell(busy) && fell_seen_q |-> strobes_q == 3'h5;
  endproperty
  property p_start;
    $rose(busy) |-> $past(run_hold);
  endproperty
  property p_wait;
    wait_q <= CYCLE_CLKS;
  endproperty
  property p_onehot;
    $onehot0(digit_sel);
  endproperty
  property p_blank;
    over_range |-> digit_sel == 5'h00;
  endproperty
  property p_order;
    $changed(digit_sel) && digit_sel != 5'h00 && $past(digit_sel) != 5'h00
      |-> digit_sel == 5'h10 || digit_sel == ($past(digit_sel) >> 1);
  endproperty
  property p_flag_set;
    $rose(under_range) || $rose(over_range) |-> $fell(busy);
  endproperty
  property p_excl;
    !(under_range && over_range);
  endproperty
  property p_under_clr;
    $rose(busy) |-> ##[0:1] !under_range;
  endproperty
  property p_over_clr;
    $fell(over_range) || $changed(polarity) |-> busy;
  endproperty

  a_period: assert property (p_period) else $error("busy period short");
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  a_strobe_mid: assert property (p_strobe_mid) else $error("strobe off mid");
  a_first: assert property (p_first) else $error("no first strobe");
  a_strobe_cnt: assert property (p_strobe_cnt) else $error("strobe count");
  a_start: assert property (p_start) else $error("start without run");
  a_wait: assert property (p_wait) else $error("run not taken");
  a_onehot: assert property (p_onehot) else $error("selects not one-hot");
  a_blank: assert property (p_blank) else $error("select while over");
  a_order: assert property (p_order) else $error("select order");
  a_flag_set: assert property (p_flag_set) else $error("flag set late");
  a_excl: assert property (p_excl) else $error("both range flags");
  a_under_clr: assert property (p_under_clr) else $error("under kept");
  a_over_clr: assert property (p_over_clr) else $error("idle change");
endmodule
`default_nettype wire

// *** dual_slope_bcd_output_sequencer_test.sv ***
// self-checking bench for the converter sequencer and its controller
`timescale 1ns/1ps
`default_nettype none
module dual_slope_bcd_output_sequencer_test;
  // ********************
  // signals and helpers
  // ********************
  localparam int CYC = 20202;
  localparam int INTC = 100;
  localparam int DMAX = 20001;
  localparam logic [3:0] TAGS [5] = '{adc_seq_pkg::TAG_DIG5,
    adc_seq_pkg::TAG_DIG4, adc_seq_pkg::TAG_DIG3, adc_seq_pkg::TAG_DIG2,
    adc_seq_pkg::TAG_DIG1};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic comp_pin = 1'b1;
  logic sign_pin = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, tx_out;
  logic [1:0] phase;
  logic [31:0] rd;
  logic er, sg, p, s;
  logic [7:0] wd [5];
  int k, t1;
  int cyc = 0;
  int err_count = 0;
  int compares = 0;

  adc_link_if i_adc_link_if ();
  adc_seq_dev #(.CYCLE_CLKS(CYC), .INT_CLKS(INTC), .DEINT_MAX_CLKS(DMAX))
    i_adc_seq_dev (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .comp_pin(comp_pin), .sign_pin(sign_pin), .phase(phase),
    .link(i_adc_link_if.dev));
  adc_seq_ctl i_adc_seq_ctl (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .tx_out(tx_out), .link(i_adc_link_if.ctl));
  adc_seq_assertions #(.CYCLE_CLKS(CYC), .INT_CLKS(INTC),
    .DEINT_MAX_CLKS(DMAX)) i_adc_seq_assertions (.core_clk(core_clk),
    .rst(rst), .run_hold(i_adc_link_if.run_hold),
    .busy(i_adc_link_if.busy), .strobe_n(i_adc_link_if.strobe_n),
    .digit_sel(i_adc_link_if.digit_sel), .bcd(i_adc_link_if.bcd),
    .polarity(i_adc_link_if.polarity),
    .over_range(i_adc_link_if.over_range),
    .under_range(i_adc_link_if.under_range));

  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic fail_wait();
    err_count++;
    tally_and_finish();
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (n > 20) fail_wait();
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ph selects de-integrate phase, otherwise busy
  task automatic wait_sig(input logic ph, input logic lvl);
    int n;
    n = 0;
    while ((ph ? (phase == 2'h2) : i_adc_link_if.busy) !== lvl) begin
      @(negedge core_clk);
      n++;
      if (n > 30000) fail_wait();
    end
  endtask

  // comparator crosses k cycles into de-integration
  task automatic convert(input int kc);
    wait_sig(1'b1, 1'b1);
    repeat (kc) @(posedge core_clk);
    comp_pin <= 1'b0;
    wait_sig(1'b0, 1'b0);
    @(posedge core_clk);
    comp_pin <= 1'b1;
    @(negedge core_clk);
  endtask

  task automatic rx(output logic [7:0] w);
    int n;
    n = 0;
    while (tx_out !== 1'b0) begin
      @(negedge core_clk);
      n++;
      if (n > 400) fail_wait();
    end
    repeat (8) @(negedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(negedge core_clk);
      w[i] = tx_out;
    end
    repeat (16) @(negedge core_clk);
    p = tx_out;
    repeat (16) @(negedge core_clk);
    s = tx_out;
  endtask

  function automatic int dec(input logic [31:0] v);
    return v[19:16] * 10000 + v[15:12] * 1000 + v[11:8] * 100 +
      v[7:4] * 10 + v[3:0];
  endfunction

  // ********************
  // main sequence
  // ********************
  initial begin
    void'($urandom(9551));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    apb(adc_seq_pkg::CTRL_OFF, 1'b0, 32'h0);
    check("ctrl_reset", rd, 32'h0);
    apb(adc_seq_pkg::IRQ_EN_OFF, 1'b0, 32'h0);
    check("irq_en_reset", rd, 32'h0);
    apb(8'h18, 1'b0, 32'h0);
    check("unmapped", {31'h0, er}, 32'h1);
    apb(adc_seq_pkg::STATUS_OFF, 1'b1, 32'h1F);
    apb(adc_seq_pkg::STATUS_OFF, 1'b0, 32'h0);
    check("status_ro", rd, 32'h0);
    apb(adc_seq_pkg::IRQ_EN_OFF, 1'b1, 32'h1);
    sg = 1'($urandom % 2);
    k = 10 + $urandom % 1700;
    sign_pin <= sg;
    apb(adc_seq_pkg::CTRL_OFF, 1'b1, 32'h2);
    convert(k);
    check("under_set", i_adc_link_if.under_range, 32'h1);
    check("over_low", i_adc_link_if.over_range, 32'h0);
    check("polarity", i_adc_link_if.polarity, sg);
    for (int d = 0; d < 5; d++) begin
      rx(wd[d]);
      check("tag", wd[d][7:4], TAGS[d]);
      check("stop", s, 32'h1);
      check("parity", p, sg ? ^wd[d] : ~^wd[d]);
    end
    check("top_flags", wd[0][3:1], {sg, 2'b01});
    check("irq_done", irq, 32'h1);
    repeat (20) @(negedge core_clk);
    apb(adc_seq_pkg::DATA_OFF, 1'b0, 32'h0);
    check("rank2", rd[16:0], {wd[0][0], wd[1][3:0], wd[2][3:0],
      wd[3][3:0], wd[4][3:0]});
    check("result", dec(rd) >= k && dec(rd) <= k + 4, 32'h1);
    apb(adc_seq_pkg::IRQ_STAT_OFF, 1'b0, 32'h0);
    check("irq_stat", rd, 32'h3);
    apb(adc_seq_pkg::IRQ_EN_OFF, 1'b1, 32'h0);
    @(negedge core_clk);
    check("irq_masked", irq, 32'h0);
    apb(adc_seq_pkg::IRQ_CLR_OFF, 1'b1, 32'h3);
    apb(adc_seq_pkg::IRQ_STAT_OFF, 1'b0, 32'h0);
    check("irq_clear", rd, 32'h0);
    apb(adc_seq_pkg::IRQ_EN_OFF, 1'b1, 32'h1);
    sg = 1'($urandom % 2);
    k = 2000 + $urandom % 7000;
    sign_pin <= sg;
    apb(adc_seq_pkg::CTRL_OFF, 1'b1, 32'h2);
    wait_sig(1'b0, 1'b1);
    repeat (2) @(negedge core_clk);
    check("under_clr", i_adc_link_if.under_range, 32'h0);
    convert(k);
    check("mid_flags", {i_adc_link_if.over_range,
      i_adc_link_if.under_range}, 32'h0);
    check("polarity2", i_adc_link_if.polarity, sg);
    check("phase_zero", phase, 32'h3);
    check("irq_done2", irq, 32'h1);
    repeat (5 * adc_seq_pkg::DIGIT_CLKS + 20) @(negedge core_clk);
    apb(adc_seq_pkg::DATA_OFF, 1'b0, 32'h0);
    check("result2", dec(rd) >= k && dec(rd) <= k + 4, 32'h1);
    apb(adc_seq_pkg::CTRL_OFF, 1'b1, 32'h1);
    wait_sig(1'b0, 1'b1);
    t1 = cyc;
    wait_sig(1'b0, 1'b0);
    @(negedge core_clk);
    check("over_set", i_adc_link_if.over_range, 32'h1);
    check("blank", i_adc_link_if.digit_sel, 32'h0);
    apb(adc_seq_pkg::STATUS_OFF, 1'b0, 32'h0);
    check("status_over", rd[4:3], 32'h1);
    wait_sig(1'b0, 1'b1);
    check("period", cyc - t1, CYC);
    repeat (INTC + 20) @(negedge core_clk);
    check("over_clr", i_adc_link_if.over_range, 32'h0);
    apb(adc_seq_pkg::CTRL_OFF, 1'b1, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
